// file: logic/usb_ctl_pkg.sv
// Purpose: Constants for the transfer-status queue and USB control block.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes:   Offsets are chosen locally; fields sit in the low byte.
//
// Notes on behaviour
// - Status bits 7:4 give last endpoint.
// - Status bit 3 gives direction, one transmit.
// - Status bit 2 gives bank, one odd.
// - Status is head of four-entry queue.
// - Status valid only while done flag set.
// - Clearing done flag pops the queue.
// - Unused status and upper bits read zero.
// - Control bit 7 shows live J state.
// - Control bit 6 shows live single-ended zero.
// - Device mode: bit 5 halts packets, SETUP sets.
// - Host mode: bit 5 shows token executing.
// - Host mode: bit 4 drives bus reset.
// - Bit 3 host enable; toggling resets host.
// - Bit 2 drives resume signalling.
// - Host mode: clearing resume appends low-speed EOP.
// - Bit 1 resets ping-pong pointers to even.
// - Device mode: bit 0 enables module.
// - Host mode: bit 0 sends SOF every 1 ms.
// - Address bit 7 selects low-speed next token.
// - Address bits 6:0 hold device address.
package usb_ctl_pkg;
   localparam logic [7:0]  STATUS_OFS    = 8'h00;  // Transfer status byte address.
   localparam logic [7:0]  CONTROL_OFS   = 8'h04;  // USB control byte address.
   localparam logic [7:0]  ADDRESS_OFS   = 8'h08;  // Device address byte address.
   localparam logic [7:0]  FLAGS_OFS     = 8'h0c;  // Interrupt flags byte address.
   localparam int          DONE_BIT      = 3;      // Transaction done flag position.
   localparam int          J_BIT         = 7;      // Live J flag position.
   localparam int          SE0_BIT       = 6;      // Live single-ended zero position.
   localparam int          PKT_BIT       = 5;      // Packet off or token busy.
   localparam int          BRST_BIT      = 4;      // Bus reset generate.
   localparam int          HOST_BIT      = 3;      // Host capability on.
   localparam int          RES_BIT       = 2;      // Resume signalling.
   localparam int          PPR_BIT       = 1;      // Ping-pong pointer reset.
   localparam int          EN_BIT        = 0;      // Module power or frame start.
   localparam int          FIFO_DEPTH    = 4;      // Status queue entries.
   localparam int          CLK_HZ        = 25000000; // Module clock rate.
   localparam int          SOF_PERIOD_US = 1000;   // Start-of-frame period in us.
   localparam int          SOF_CYCLES    = CLK_HZ / 1000000 * SOF_PERIOD_US;
   localparam int          EOP_NS        = 1330;   // Low-speed EOP length in ns.
   localparam int          EOP_CYCLES    = (EOP_NS * 25 + 999) / 1000;
   localparam logic [6:0]  STATUS_RESET  = 7'h00;  // Queue entry reset value.
   localparam logic [7:0]  BYTE_RESET    = 8'h00;  // Control and address reset value.
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000; // Read data at unmapped address.
   typedef enum logic [1:0] {EOP_IDLE, EOP_SEND} eop_state_type;
endpackage

// file: logic/usb_status_ctl.sv
// Purpose: Transfer-status queue, USB control and device address registers.
// Assumes: APB slave answering with pready high in the access cycle.
// Notes:   Event inputs are one-cycle pulses from the packet engine.
`timescale 1ns/100ps
`default_nettype none
module usb_status_ctl
   import usb_ctl_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   // APB slave.
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Packet engine events.
   input  wire logic        trans_done_in,
   input  wire logic [3:0]  trans_endpoint_in,
   input  wire logic        trans_tx_in,
   input  wire logic        trans_odd_in,
   input  wire logic        setup_seen_in,
   input  wire logic        token_active_in,
   // Live bus line state.
   input  wire logic        live_j_in,
   input  wire logic        live_se0_in,
   // Bus control outputs.
   output logic             bus_reset_out,
   output logic             resume_out,
   output logic             ls_eop_out,
   output logic             host_logic_reset_out,
   output logic             pingpong_clear_out,
   output logic             module_enable_out,
   output logic             packet_halt_out,
   output logic             sof_pulse_out,
   output logic             low_speed_next_out,
   output logic [6:0]       device_number_out,
   output logic             status_full_out
);
   // Every piece of state in one record.
   typedef struct packed {
      logic [3:0][6:0] fifo;      // Status queue storage.
      logic [1:0]      rd_ptr;    // Head index.
      logic [1:0]      wr_ptr;    // Tail index.
      logic [2:0]      count;     // Entries held.
      logic [5:0]      ctl;       // Writable control bits 5:0.
      logic [7:0]      addr;      // Device address register.
      logic            host_rst;  // Host logic reset pulse.
      logic [14:0]     sof_cnt;   // Frame timer.
      logic            sof;       // Frame start pulse.
      eop_state_type   eop_st;    // Low-speed EOP sequencer.
      logic [5:0]      eop_cnt;   // EOP cycle count.
   } state_type;

   state_type st_r;   // Registered state.
   state_type st_nxt; // Next state.

   logic wr_acc;   // Write access phase.
   logic rd_acc;   // Read access phase.
   logic host;     // Host mode active.
   logic [7:0] control_view; // Control register as read.
   logic [7:0] status_view;  // Head entry as read.

   // Builds a queue entry from its three fields; the entry is the status byte
   // without its lowest bit, so bit 0 of the entry is always zero.
   function automatic logic [6:0] pack_entry(input logic [3:0] ep, input logic tx,
                                             input logic odd);
      pack_entry = {ep, tx, odd, 1'b0};
   endfunction

   assign wr_acc = psel_in & penable_in & pwrite_in;
   assign rd_acc = psel_in & penable_in & ~pwrite_in;
   assign host   = st_r.ctl[HOST_BIT];
   // Bit 5 is a busy indicator in host mode, a writable halt otherwise.
   assign control_view = {live_j_in, live_se0_in,
                          host ? token_active_in : st_r.ctl[PKT_BIT],
                          st_r.ctl[4:0]};
   // The head shows only while the done flag is up; otherwise zero.
   assign status_view = (st_r.count != 3'd0) ?
                        {st_r.fifo[st_r.rd_ptr], 1'b0} : 8'h00;

   // Next-state logic for the register file, queue and sequencers.
   always_comb begin
      logic push;
      logic pop;
      push   = 1'b0;
      pop    = 1'b0;
      st_nxt = st_r;
      st_nxt.host_rst = 1'b0;
      st_nxt.sof      = 1'b0;
      // Pop when software writes one to the done flag while it is up.
      pop  = wr_acc && (paddr_in == FLAGS_OFS) && pwdata_in[DONE_BIT]
             && (st_r.count != 3'd0);
      // A full queue refuses the push unless a pop frees a slot in the same cycle, so no unread entry is lost.
      push = trans_done_in && ((st_r.count != 3'(FIFO_DEPTH)) || pop);
      if (push) begin
         st_nxt.fifo[st_r.wr_ptr] = pack_entry(trans_endpoint_in, trans_tx_in,
                                               trans_odd_in);
         st_nxt.wr_ptr = st_r.wr_ptr + 2'd1;
      end
      if (pop) begin
         st_nxt.rd_ptr = st_r.rd_ptr + 2'd1;
      end
      st_nxt.count = st_r.count + {2'b00, push} - {2'b00, pop};
      // Register writes.
      if (wr_acc && (paddr_in == CONTROL_OFS)) begin
         st_nxt.ctl = pwdata_in[5:0];
         if (pwdata_in[HOST_BIT] != st_r.ctl[HOST_BIT]) begin
            st_nxt.host_rst = 1'b1;
         end
         // Clearing resume in host mode launches the trailing EOP.
         if (st_r.ctl[RES_BIT] && !pwdata_in[RES_BIT] && host) begin
            st_nxt.eop_st  = EOP_SEND;
            st_nxt.eop_cnt = 6'd0;
         end
      end
      if (wr_acc && (paddr_in == ADDRESS_OFS)) begin
         st_nxt.addr = pwdata_in[7:0];
      end
      // A SETUP token sets the halt bit in device mode; it wins over a write.
      if (setup_seen_in && !host) begin
         st_nxt.ctl[PKT_BIT] = 1'b1;
      end
      // Frame timer runs only while frame start is enabled in host mode.
      if (host && st_r.ctl[EN_BIT]) begin
         if (st_r.sof_cnt == 15'(SOF_CYCLES - 1)) begin
            st_nxt.sof_cnt = 15'd0;
            st_nxt.sof     = 1'b1;
         end else begin
            st_nxt.sof_cnt = st_r.sof_cnt + 15'd1;
         end
      end else begin
         st_nxt.sof_cnt = 15'd0;
      end
      // EOP sequencer.
      case (st_r.eop_st)
         EOP_IDLE: begin
         end
         EOP_SEND: begin
            if (st_r.eop_cnt == 6'(EOP_CYCLES - 1)) begin
               st_nxt.eop_st = EOP_IDLE;
            end else begin
               st_nxt.eop_cnt = st_r.eop_cnt + 6'd1;
            end
         end
         default: st_nxt.eop_st = EOP_IDLE;
      endcase
   end

   // State register; all control clears on reset.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Read data comes straight from the register views so the answer is
   // zero-wait; the price is that it is only meaningful in the access phase.
   always_comb begin
      case (paddr_in)
         STATUS_OFS:  prdata_out = {24'h000000, status_view};
         CONTROL_OFS: prdata_out = {24'h000000, control_view};
         ADDRESS_OFS: prdata_out = {24'h000000, st_r.addr};
         FLAGS_OFS:   prdata_out = {28'h0000000, (st_r.count != 3'd0), 3'b000};
         default:     prdata_out = UNMAPPED_DATA;
      endcase
   end

   assign pready_out           = 1'b1;
   // Addresses above the flags offset answer with an error so software notices a bad map.
   assign pslverr_out          = psel_in & penable_in & (paddr_in > FLAGS_OFS);
   assign bus_reset_out        = host & st_r.ctl[BRST_BIT];
   assign resume_out           = st_r.ctl[RES_BIT];
   assign ls_eop_out           = (st_r.eop_st == EOP_SEND);
   assign host_logic_reset_out = st_r.host_rst;
   assign pingpong_clear_out   = st_r.ctl[PPR_BIT];
   assign module_enable_out    = ~host & st_r.ctl[EN_BIT];
   assign packet_halt_out      = ~host & st_r.ctl[PKT_BIT];
   assign sof_pulse_out        = st_r.sof;
   assign low_speed_next_out   = st_r.addr[7];
   assign device_number_out    = st_r.addr[6:0];
   assign status_full_out      = (st_r.count == 3'(FIFO_DEPTH));

   // Checks on the block's behaviour.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   status_zero_a: assert property ((st_r.count == 3'd0) |-> status_view == 8'h00)
      else $error("status not zero while queue empty");
   queue_bound_a: assert property (st_r.count <= 3'd4)
      else $error("queue count above four");
   no_overwrite_a: assert property (status_full_out && trans_done_in && !wr_acc
      |=> status_full_out && $stable(st_r.fifo)) else $error("full queue lost an entry");
   push_count_a: assert property (trans_done_in && st_r.count < 3'd4 && !wr_acc
      |=> st_r.count == $past(st_r.count) + 3'd1) else $error("push not counted");
   pop_adv_a: assert property (wr_acc && paddr_in == FLAGS_OFS && pwdata_in[3]
      && st_r.count != 3'd0 && !trans_done_in |=> st_r.count == $past(st_r.count) - 3'd1)
      else $error("clear did not pop");
   setup_halt_a: assert property (setup_seen_in && !host |=> st_r.ctl[5])
      else $error("setup did not halt packets");
   host_tog_a: assert property (wr_acc && paddr_in == CONTROL_OFS
      && pwdata_in[3] != st_r.ctl[3] |=> host_logic_reset_out)
      else $error("host toggle gave no reset");
   eop_len_a: assert property ($rose(ls_eop_out) |-> ls_eop_out [*8] ##27 !ls_eop_out)
      else $error("eop length wrong");
   sof_off_a: assert property (!(host && st_r.ctl[0]) |=> !sof_pulse_out)
      else $error("frame start while disabled");
   upper_zero_a: assert property (prdata_out[31:8] == 24'h000000)
      else $error("upper read bits not zero");

   fill_c: cover property (st_r.count == 3'd4);
   eop_c: cover property ($rose(ls_eop_out));
   sof_c: cover property (sof_pulse_out);
endmodule
`default_nettype wire

// file: bench/usb_far_end.sv
// Purpose: Far-side stand-in for packet engine events and live bus lines.
// Assumes: Events launch just after a rising edge and last one cycle.
// Notes:   Qualifiers are inverted after each event so stale data never matches.
`timescale 1ns/100ps
`default_nettype none
module usb_far_end (
   // Clock.
   input  wire logic       clk_in,
   // Transaction events.
   output logic            done_out,
   output logic [3:0]      ep_out,
   output logic            tx_out,
   output logic            odd_out,
   output logic            setup_out,
   // Live line and token state.
   output logic            busy_out,
   output logic            j_out,
   output logic            se0_out
);
   // Everything idles low until the bench asks for traffic.
   initial begin
      {done_out, ep_out, tx_out, odd_out, setup_out, busy_out, j_out, se0_out} = '0;
   end
   // One completed transfer; the qualifiers are valid with the pulse only.
   task automatic xfer(input logic [3:0] ep, input logic tx, input logic odd);
      @(posedge clk_in);
      done_out <= 1'b1;
      {ep_out, tx_out, odd_out} <= {ep, tx, odd};
      @(posedge clk_in);
      done_out <= 1'b0;
      {ep_out, tx_out, odd_out} <= ~{ep, tx, odd};
   endtask
   // A SETUP token seen on the cable.
   task automatic setup();
      @(posedge clk_in);
      setup_out <= 1'b1;
      @(posedge clk_in);
      setup_out <= 1'b0;
   endtask
   // Live line levels and the token engine state.
   task automatic lines(input logic j, input logic se0, input logic busy);
      @(posedge clk_in);
      {j_out, se0_out, busy_out} <= {j, se0, busy};
   endtask
endmodule
`default_nettype wire

// file: bench/usb_status_fifo_and_control_tb.sv
// Purpose: Self-checking bench for the status queue and control registers.
// Assumes: Zero-wait APB slave; far side modelled by usb_far_end.
// Notes:   Three full frame periods are run, two with frame start on, so the run is long but bounded.
`timescale 1ns/100ps
`default_nettype none
module usb_status_fifo_and_control_tb;
   import usb_ctl_pkg::*;
   logic        clk_in = 1'b0;     // Module clock.
   logic        reset_n_in = 1'b0; // Asynchronous reset, low active.
   logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
   logic        pready_out, pslverr_out, err, done, tx, odd, setup, busy, j, se0;
   logic [3:0]  ep;
   logic        bus_reset_out, resume_out, ls_eop_out, host_logic_reset_out;
   logic        pingpong_clear_out, module_enable_out, packet_halt_out, sof_pulse_out;
   logic        low_speed_next_out, status_full_out;
   logic [6:0]  device_number_out;
   int          num_errors = 0, compares = 0, cyc = 0, hrst_n = 0, eop_n = 0;
   int          sof_n = 0, sof_last = 0, sof_gap = 0, snap;
   usb_status_ctl dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .trans_done_in(done), .trans_endpoint_in(ep),
      .trans_tx_in(tx), .trans_odd_in(odd), .setup_seen_in(setup),
      .token_active_in(busy), .live_j_in(j), .live_se0_in(se0),
      .bus_reset_out(bus_reset_out), .resume_out(resume_out), .ls_eop_out(ls_eop_out),
      .host_logic_reset_out(host_logic_reset_out), .pingpong_clear_out(pingpong_clear_out),
      .module_enable_out(module_enable_out), .packet_halt_out(packet_halt_out),
      .sof_pulse_out(sof_pulse_out), .low_speed_next_out(low_speed_next_out),
      .device_number_out(device_number_out), .status_full_out(status_full_out));
   usb_far_end far (.clk_in(clk_in), .done_out(done), .ep_out(ep), .tx_out(tx),
      .odd_out(odd), .setup_out(setup), .busy_out(busy), .j_out(j), .se0_out(se0));
   always #20 clk_in = ~clk_in;
   // Event counters; a hang past the ceiling ends the run as a mismatch.
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (host_logic_reset_out === 1'b1) hrst_n <= hrst_n + 1;
      if (ls_eop_out === 1'b1) eop_n <= eop_n + 1;
      if (sof_pulse_out === 1'b1) begin
         sof_n <= sof_n + 1;
         sof_gap <= cyc - sof_last;
         sof_last <= cyc;
      end
      if (cyc == 90000) begin
         num_errors = num_errors + 1;
         close_out();
      end
   end
   // Compares one value; unknown bits never pass.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; data and error are taken at the edge where pready is high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic rdy = 1'b0;
      int   n = 0;
      @(posedge clk_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
         rdy = (pready_out === 1'b1);
      end while (!rdy && n < 16);
      {rd, err} = {prdata_out, pslverr_out};
      if (!rdy) num_errors++;
      {psel_in, penable_in} <= 2'b00;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic close_out();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Main sequence: reset values, address, live flags, queue, device and host control.
   initial begin
      repeat (20) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rchk("control", CONTROL_OFS, 32'h0);
      rchk("address", ADDRESS_OFS, 32'h0);
      rchk("flags", FLAGS_OFS, 32'h0);
      apb(1'b1, ADDRESS_OFS, 32'hffff_ffa5);
      rchk("address", ADDRESS_OFS, 32'h0000_00a5);
      chk("low speed", 32'h1, 32'(low_speed_next_out));
      chk("device number", 32'h25, 32'(device_number_out));
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      far.lines(1'b1, 1'b0, 1'b0);
      rchk("control", CONTROL_OFS, 32'h80);
      far.lines(1'b0, 1'b1, 1'b0);
      rchk("control", CONTROL_OFS, 32'h40);
      far.lines(1'b0, 1'b0, 1'b0);
      // Five transfers into a four-entry queue: the last must be dropped.
      for (int i = 0; i < 5; i++) far.xfer(4'(i + 9), i[0], i[1]);
      @(negedge clk_in);
      chk("full", 32'h1, 32'(status_full_out));
      for (int i = 0; i < 4; i++) begin
         rchk("flags", FLAGS_OFS, 32'h08);
         rchk("status", STATUS_OFS, {24'h0, 4'(i + 9), i[0], i[1], 2'b00});
         apb(1'b1, FLAGS_OFS, 32'h08);
      end
      rchk("flags", FLAGS_OFS, 32'h0);
      apb(1'b1, CONTROL_OFS, 32'h03);
      far.setup();
      rchk("control", CONTROL_OFS, 32'h23);
      chk("device pins", 32'h7, {packet_halt_out, module_enable_out, pingpong_clear_out});
      apb(1'b1, CONTROL_OFS, 32'h18);
      far.lines(1'b0, 1'b0, 1'b1);
      rchk("control", CONTROL_OFS, 32'h38);
      chk("host pins", 32'h4, {bus_reset_out, packet_halt_out, module_enable_out});
      apb(1'b1, CONTROL_OFS, 32'h0c);
      far.lines(1'b0, 1'b0, 1'b0);
      chk("resume on", 32'h1, {bus_reset_out, resume_out});
      // The resume hold is cut far below its real length to keep the run short.
      apb(1'b1, CONTROL_OFS, 32'h08);
      repeat (EOP_CYCLES + 5) @(posedge clk_in);
      chk("eop cycles", 32'(EOP_CYCLES), 32'(eop_n));
      chk("resume off", 32'h0, 32'(resume_out));
      apb(1'b1, CONTROL_OFS, 32'h09);
      repeat (2 * SOF_CYCLES + 10) @(posedge clk_in);
      chk("frame gap", 32'(SOF_CYCLES), 32'(sof_gap));
      apb(1'b1, CONTROL_OFS, 32'h00);
      snap = sof_n;
      repeat (SOF_CYCLES + 10) @(posedge clk_in);
      chk("frames off", 32'(snap), 32'(sof_n));
      chk("host resets", 32'h2, 32'(hrst_n));
      close_out();
   end
endmodule
`default_nettype wire
